//--- mmd_core_model.sv
/* Core model: forms the flag register the decoder sees.
   Assumes the bench chooses the bank and orders any faults. */
`timescale 1ns/100ps
`default_nettype none
module mmd_core_model (
  input  wire logic       bank_i,
  input  wire logic       bad_i,
  output logic [7:0] flag_o
);
  // The reserved bits go high only when a scenario orders the fault.
  assign flag_o = {bad_i, bad_i, bank_i, 5'h05};
endmodule : mmd_core_model
`default_nettype wire

//--- mmd_decoder.sv
/*
  Memory map decoder: program counter with wrap and vectors, banked data
  address decode, special-function register file, shared GPR RAM.
  Assumes the core presents one data access per cycle and reads answer one
  cycle after the request, synchronous to MCLK_I.
  Read data and the last read's address stand until the next read.
  The flag register and indirect pointer are driven by the core itself.
*/
`timescale 1ns/100ps
`default_nettype none
module mmd_decoder
  import mmd_pkg::*;
(
  // Clock and reset
  input  wire logic                        MCLK_I,
  input  wire logic                        RESET_N_I,
  // Program counter control
  input  wire logic                        PC_LOAD_I,
  input  wire logic [mmd_pkg::PC_W-1:0]    PC_VALUE_I,
  input  wire logic                        PC_INC_I,
  input  wire logic                        IRQ_TAKE_I,
  // Data access
  input  wire logic                        D_REQ_I,
  input  wire logic                        D_WR_I,
  input  wire logic                        D_INDIRECT_I,
  input  wire logic [mmd_pkg::FILE_W-1:0]  D_FILE_ADDR_I,
  input  wire logic [mmd_pkg::DATA_W-1:0]  D_WDATA_I,
  // Core flags and pointer
  input  wire logic [mmd_pkg::DATA_W-1:0]  FLAG_REG_I,
  input  wire logic [mmd_pkg::DATA_W-1:0]  INDIRECT_POINTER_REGISTER_I,
  // Outputs
  output logic [mmd_pkg::PC_W-1:0]         PC_O,
  output logic [mmd_pkg::PROG_W-1:0]       PROG_ADDR_O,
  output logic [mmd_pkg::DATA_W-1:0]       D_RDATA_O,
  output logic [mmd_pkg::DADDR_W-1:0]      D_ADDR_O,
  output logic                             BANK_SELECT_BIT_O,
  output logic                             RESERVED_FLAG_ERR_O
);
  // Two banks of special-function storage, indexed by the low file bits.
  localparam int N_BANK    = 2;
  localparam int SFR_IDX_W = $clog2(SFR_COUNT);

  // Reset image of the whole state. Every field is a constant, so the
  // asynchronous reset branch carries no logic of its own.
  localparam mmd_state_type ST_RESET = '{
    pc:        RESET_VEC,
    prog_addr: RESET_VEC[PROG_W-1:0],
    rdata:     ZERO_BYTE,
    daddr:     '0,
    bank:      1'b0,
    rsv_err:   1'b0
  };

  // Registered state.
  mmd_state_type      st_r;
  mmd_state_type      st_nxt;

  // Storage and read paths.
  logic [DATA_W-1:0]  sfr_r [N_BANK][SFR_COUNT];
  logic [DATA_W-1:0]  sfr_rdata;
  logic [DATA_W-1:0]  gpr_rdata;
  logic [DATA_W-1:0]  rd_byte;

  // Address decode.
  logic               bank_select_bit;
  logic               rd_req;
  logic               wr_req;
  logic [DADDR_W-1:0] daddr;
  logic [FILE_W-1:0]  foff;
  logic               dbank;
  logic               ind_slot;
  mmd_region_type     region;
  mmd_ram_req_type    ram_req;
  logic [PC_W-1:0]    pc_next;

  // The bank bit is taken from the live flag value, so a bank switch by
  // the core applies to the very next direct access.
  assign bank_select_bit = FLAG_REG_I[BANK_BIT];
  assign rd_req          = D_REQ_I && !D_WR_I;
  assign wr_req          = D_REQ_I && D_WR_I;

  // Indirect accesses take the full 8-bit pointer, so they reach either
  // bank without touching the bank bit; direct ones stack the bank bit
  // over the instruction's file address.
  always_comb begin
    if (D_INDIRECT_I) begin
      daddr = INDIRECT_POINTER_REGISTER_I;
    end else begin
      daddr = {bank_select_bit, D_FILE_ADDR_I};
    end
    dbank    = daddr[DADDR_W-1];
    foff     = daddr[FILE_W-1:0];
    ind_slot = (foff == INDIRECT_A);
  end

  // Both banks share one layout, so the region depends on the offset only.
  always_comb begin
    if (foff <= SFR_LAST) begin
      region = MMD_RGN_SFR;
    end else if (foff >= GPR_FIRST && foff <= GPR_LAST) begin
      region = MMD_RGN_GPR;
    end else begin
      region = MMD_RGN_NONE;
    end
  end

  // Dropping the bank bit and rebasing the offset folds both banks onto
  // one set of bytes, which makes the upper bank's window an alias of the
  // lower one for reads and writes alike.
  always_comb begin
    ram_req.wr    = wr_req && (region == MMD_RGN_GPR);
    ram_req.addr  = GPR_W'(foff - GPR_FIRST);
    ram_req.wdata = D_WDATA_I;
  end

  // The store reads without a clock so its byte can land in the same
  // output flop as the special-function bytes; a write and a read of one
  // byte in back-to-back cycles then sees the new value.
  mmd_gpr_ram #(
    .DEPTH (GPR_DEPTH)
  ) u_gpr (
    .clk_i   (MCLK_I),
    .req_i   (ram_req),
    .rdata_o (gpr_rdata)
  );

  // The indirect slot has no storage of its own and always reads zero.
  always_comb begin
    if (ind_slot) begin
      sfr_rdata = ZERO_BYTE;
    end else begin
      sfr_rdata = sfr_r[dbank][foff[SFR_IDX_W-1:0]];
    end
  end

  // Anything outside the two implemented regions answers with zero.
  always_comb begin
    case (region)
      MMD_RGN_SFR: begin
        rd_byte = sfr_rdata;
      end
      MMD_RGN_GPR: begin
        rd_byte = gpr_rdata;
      end
      default: begin
        rd_byte = ZERO_BYTE;
      end
    endcase
  end

  // Interrupt entry outranks an explicit load, which outranks increment.
  // The full 13-bit count is kept; only the fetch address is cut down.
  always_comb begin
    if (IRQ_TAKE_I) begin
      pc_next = IRQ_VEC;
    end else if (PC_LOAD_I) begin
      pc_next = PC_VALUE_I;
    end else if (PC_INC_I) begin
      pc_next = PC_W'(st_r.pc + PC_W'(1));
    end else begin
      pc_next = st_r.pc;
    end
  end

  // Fetches above the implemented words simply drop the upper count bits,
  // so they wrap into the first block instead of faulting.
  always_comb begin
    st_nxt           = st_r;
    st_nxt.pc        = pc_next;
    st_nxt.prog_addr = pc_next[PROG_W-1:0];
    st_nxt.bank      = bank_select_bit;
    // Reserved flag bits are software's to keep clear; flag any lapse.
    st_nxt.rsv_err   = FLAG_REG_I[IPAGE_BIT] | FLAG_REG_I[UBANK_BIT];
    // Read data and address stand until the next read replaces them.
    if (rd_req) begin
      st_nxt.daddr = daddr;
      st_nxt.rdata = rd_byte;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Static special-function storage. It has no reset and simply holds
  // what was last written, so a reset leaves its contents in place.
  for (genvar b = 0; b < N_BANK; b++) begin : g_bank
    for (genvar i = 0; i < SFR_COUNT; i++) begin : g_sfr
      always_ff @(posedge MCLK_I) begin
        if (wr_req && region == MMD_RGN_SFR && !ind_slot
            && dbank == 1'(b) && foff == FILE_W'(i)) begin
          sfr_r[b][i] <= D_WDATA_I;
        end
      end
    end
  end

  // Every output is a field of the registered state.
  assign PC_O                = st_r.pc;
  assign PROG_ADDR_O         = st_r.prog_addr;
  assign D_RDATA_O           = st_r.rdata;
  assign D_ADDR_O            = st_r.daddr;
  assign BANK_SELECT_BIT_O   = st_r.bank;
  assign RESERVED_FLAG_ERR_O = st_r.rsv_err;
endmodule : mmd_decoder
`default_nettype wire

//--- mmd_decoder_assertions.sv
/* Port assertions for the decoder.
   Assumes one clock and a bind to every decoder. */
`timescale 1ns/100ps
`default_nettype none
module mmd_chk
  import mmd_pkg::*;
(
  input wire logic MCLK_I, RESET_N_I, PC_LOAD_I, PC_INC_I, IRQ_TAKE_I,
  input wire logic D_REQ_I, D_WR_I, D_INDIRECT_I, BANK_SELECT_BIT_O, RESERVED_FLAG_ERR_O,
  input wire logic [PC_W-1:0]    PC_VALUE_I, PC_O,
  input wire logic [FILE_W-1:0]  D_FILE_ADDR_I,
  input wire logic [DATA_W-1:0]  FLAG_REG_I, D_RDATA_O,
  input wire logic [DATA_W-1:0]  INDIRECT_POINTER_REGISTER_I,
  input wire logic [PROG_W-1:0]  PROG_ADDR_O,
  input wire logic [DADDR_W-1:0] D_ADDR_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_dir_rd; D_REQ_I && !D_WR_I && !D_INDIRECT_I; endsequence
  sequence s_ind_rd; D_REQ_I && !D_WR_I && D_INDIRECT_I; endsequence
  AST_IRQ: assert property (IRQ_TAKE_I |=> PC_O == IRQ_VEC)
    else $error("pc missed vector");
  AST_LOAD: assert property (PC_LOAD_I && !IRQ_TAKE_I |=> PC_O == $past(PC_VALUE_I))
    else $error("pc load lost");
  AST_INC: assert property (
    PC_INC_I && !PC_LOAD_I && !IRQ_TAKE_I |=> PC_O == $past(PC_O) + 13'h0001)
    else $error("pc step wrong");
  AST_WRAP: assert property (PROG_ADDR_O == PC_O[9:0])
    else $error("fetch not wrapped");
  AST_BANK: assert property (
    $past(RESET_N_I) |-> BANK_SELECT_BIT_O == $past(FLAG_REG_I[5])) else $error("bank");
  AST_RSV: assert property (
    $past(RESET_N_I) |-> RESERVED_FLAG_ERR_O == (|$past(FLAG_REG_I[7:6]))) else $error("rsv");
  AST_DADDR: assert property (
    s_dir_rd |=> D_ADDR_O == {$past(FLAG_REG_I[5]), $past(D_FILE_ADDR_I)}) else $error("daddr");
  AST_IND: assert property (
    s_ind_rd |=> D_ADDR_O == $past(INDIRECT_POINTER_REGISTER_I)) else $error("ind addr");
  AST_ZERO: assert property (
    s_dir_rd ##0 (D_FILE_ADDR_I >= 7'h60 || D_FILE_ADDR_I == 7'h00) |=> D_RDATA_O == 8'h00)
    else $error("not zero");
endmodule : mmd_chk
bind mmd_decoder mmd_chk i_chk (.*);
`default_nettype wire

//--- mmd_gpr_ram.sv
/*
  General-purpose byte store of the decoder, one clocked write port and
  one unclocked read port.
  Assumes the decoder has already folded bank aliases into a 6-bit index.
*/
`timescale 1ns/100ps
`default_nettype none
module mmd_gpr_ram
  import mmd_pkg::*;
#(
  parameter int DEPTH = GPR_DEPTH
) (
  input  wire logic                  clk_i,
  input  wire mmd_pkg::mmd_ram_req_type req_i,
  output logic [mmd_pkg::DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem_r [DEPTH];

  // The store holds its bytes between accesses and has no reset.
  always_ff @(posedge clk_i) begin
    if (req_i.wr) begin
      mem_r[req_i.addr] <= req_i.wdata;
    end
  end

  // Reads are unclocked; the decoder registers the byte it picks.
  assign rdata_o = mem_r[req_i.addr];
endmodule : mmd_gpr_ram
`default_nettype wire

//--- mmd_pkg.sv
/*
  Package for the memory map decoder: address widths, region bounds, vectors
  and the packed carriers shared by the decoder and its RAM.
  Assumes a single core clock and no other users of these names.
*/
package mmd_pkg;
  localparam int PC_W        = 13;
  localparam int PROG_W      = 10;
  localparam int FILE_W      = 7;
  localparam int DADDR_W     = 8;
  localparam int GPR_W       = 6;
  localparam int DATA_W      = 8;
  localparam int GPR_DEPTH   = 64;
  localparam int SFR_COUNT   = 32;
  localparam int BANK_BIT    = 5;
  localparam int IPAGE_BIT   = 7;
  localparam int UBANK_BIT   = 6;

  localparam logic [PC_W-1:0]    RESET_VEC  = 13'h0000;
  localparam logic [PC_W-1:0]    IRQ_VEC    = 13'h0004;
  localparam logic [FILE_W-1:0]  SFR_LAST   = 7'h1F;
  localparam logic [FILE_W-1:0]  GPR_FIRST  = 7'h20;
  localparam logic [FILE_W-1:0]  GPR_LAST   = 7'h5F;
  localparam logic [FILE_W-1:0]  INDIRECT_A = 7'h00;
  localparam logic [DATA_W-1:0]  ZERO_BYTE  = 8'h00;

  typedef enum logic [1:0] {MMD_RGN_SFR, MMD_RGN_GPR, MMD_RGN_NONE} mmd_region_type;

  typedef struct packed {
    logic              wr;
    logic [GPR_W-1:0]  addr;
    logic [DATA_W-1:0] wdata;
  } mmd_ram_req_type;

  typedef struct packed {
    logic [PC_W-1:0]    pc;
    logic [PROG_W-1:0]  prog_addr;
    logic [DATA_W-1:0]  rdata;
    logic [DADDR_W-1:0] daddr;
    logic               bank;
    logic               rsv_err;
  } mmd_state_type;
endpackage : mmd_pkg

//--- tb_top.sv
/* Bench for the decoder: program counter, banked data map, zero reads.
   Assumes the core model and the bound checker are compiled with it. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mmd_pkg::*;
  logic MCLK_I, RESET_N_I, PC_LOAD_I, PC_INC_I, IRQ_TAKE_I, D_REQ_I, D_WR_I, D_INDIRECT_I;
  logic BANK_SELECT_BIT_O, RESERVED_FLAG_ERR_O, bnk, bad;
  logic [PC_W-1:0]    PC_VALUE_I, PC_O;
  logic [FILE_W-1:0]  D_FILE_ADDR_I;
  logic [DATA_W-1:0]  D_WDATA_I, FLAG_REG_I, INDIRECT_POINTER_REGISTER_I, D_RDATA_O;
  logic [PROG_W-1:0]  PROG_ADDR_O;
  logic [DADDR_W-1:0] D_ADDR_O;
  logic [6:0]         z [4] = '{7'h60, 7'h7F, 7'h00, 7'h60};
  int                 n_mismatch, n_tests, cyc;
  mmd_core_model i_core (.bank_i(bnk), .bad_i(bad), .flag_o(FLAG_REG_I));
  mmd_decoder i_dut (.*);
  initial begin
    MCLK_I = 1'b0;
    forever #4 MCLK_I = ~MCLK_I;
  end
  task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  // Inputs move 1 ns after the edge, so no sampling race with the decoder.
  task automatic tick;
    @(posedge MCLK_I);
    #1;
  endtask : tick
  task automatic pcs(input logic l, i, q, input logic [12:0] v, e);
    PC_LOAD_I = l;
    PC_INC_I = i;
    IRQ_TAKE_I = q;
    PC_VALUE_I = v;
    tick();
    chk(PC_O, e);
    chk(PROG_ADDR_O, e[9:0]);
  endtask : pcs
  task automatic acc(input logic w, n, b, input logic [6:0] a, input logic [7:0] d);
    D_REQ_I = 1'b1;
    D_WR_I = w;
    D_INDIRECT_I = n;
    bnk = b;
    D_FILE_ADDR_I = a;
    D_WDATA_I = d;
    tick();
    if (!w) chk(D_RDATA_O, d);
    if (!w) chk(D_ADDR_O, n ? INDIRECT_POINTER_REGISTER_I : {b, a});
    chk(BANK_SELECT_BIT_O, b);
    chk(RESERVED_FLAG_ERR_O, 1'b0);
  endtask : acc
  initial begin
    {RESET_N_I, PC_LOAD_I, PC_INC_I, IRQ_TAKE_I, D_REQ_I, D_WR_I, D_INDIRECT_I, bnk, bad,
     PC_VALUE_I, D_FILE_ADDR_I, D_WDATA_I, INDIRECT_POINTER_REGISTER_I} = '0;
    repeat (3) @(posedge MCLK_I);
    #1;
    RESET_N_I = 1'b1;
    chk(PC_O, RESET_VEC);
    pcs(1'b0, 1'b1, 1'b0, 13'h0000, 13'h0001);
    pcs(1'b1, 1'b1, 1'b0, 13'h1FFF, 13'h1FFF);
    pcs(1'b0, 1'b1, 1'b0, 13'h0000, 13'h0000);
    pcs(1'b1, 1'b0, 1'b0, 13'h0BFE, 13'h0BFE);
    pcs(1'b1, 1'b1, 1'b1, 13'h1234, IRQ_VEC);
    pcs(1'b0, 1'b0, 1'b0, 13'h0000, IRQ_VEC);
    for (int k = 8'h20; k < 8'h60; k++) acc(1'b1, 1'b0, k[0], k[6:0], k[7:0] ^ 8'hA5);
    for (int k = 8'h20; k < 8'h60; k++) acc(1'b0, 1'b0, ~k[0], k[6:0], k[7:0] ^ 8'hA5);
    INDIRECT_POINTER_REGISTER_I = 8'hC7;
    acc(1'b0, 1'b1, 1'b0, 7'h00, 8'hE2);
    INDIRECT_POINTER_REGISTER_I = 8'h30;
    acc(1'b1, 1'b1, 1'b0, 7'h00, 8'h5A);
    acc(1'b0, 1'b0, 1'b1, 7'h30, 8'h5A);
    foreach (z[j]) begin
      acc(1'b1, 1'b0, j[0], z[j], 8'hFF);
      acc(1'b0, 1'b0, j[0], z[j], 8'h00);
    end
    acc(1'b1, 1'b0, 1'b0, 7'h05, 8'h3C);
    acc(1'b1, 1'b0, 1'b1, 7'h05, 8'hC3);
    D_REQ_I = 1'b0;
    bad = 1'b1;
    tick();
    chk(BANK_SELECT_BIT_O, 1'b1);
    chk(RESERVED_FLAG_ERR_O, 1'b1);
    bad = 1'b0;
    RESET_N_I = 1'b0;
    tick();
    RESET_N_I = 1'b1;
    chk(PC_O, RESET_VEC);
    acc(1'b0, 1'b0, 1'b0, 7'h05, 8'h3C);
    acc(1'b0, 1'b0, 1'b1, 7'h05, 8'hC3);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
